//--- rtl/ptev_regs.svh
// Register offsets, field positions and constants of the pin task event unit
`ifndef PTEV_REGS_SVH
`define PTEV_REGS_SVH
`define PTEV_NCH          8
`define PTEV_SEC_BASE     32'h5000d000
`define PTEV_NSEC_BASE    32'h40031000
`define PTEV_OFF_OUT      12'h000
`define PTEV_OFF_SET      12'h030
`define PTEV_OFF_CLR      12'h060
`define PTEV_OFF_SUB_OUT  12'h080
`define PTEV_OFF_SUB_SET  12'h0b0
`define PTEV_OFF_SUB_CLR  12'h0e0
`define PTEV_OFF_EV_IN    12'h100
`define PTEV_OFF_EV_PORT  12'h17c
`define PTEV_OFF_PUB_IN   12'h180
`define PTEV_OFF_PUB_PORT 12'h1fc
`define PTEV_OFF_INTERRUPT_ENABLE_SET 12'h304
`define PTEV_OFF_INTERRUPT_ENABLE_CLEAR 12'h308
`define PTEV_OFF_CFG      12'h510
`define PTEV_STRIDE       12'h004
`define PTEV_SPAN         12'h020
`define PTEV_CFG_MODE_MSB 1
`define PTEV_CFG_MODE_LSB 0
`define PTEV_CFG_PSEL_LSB 8
`define PTEV_CFG_POL_MSB  17
`define PTEV_CFG_POL_LSB  16
`define PTEV_CFG_INIT_BIT 20
`define PTEV_LINK_EN_BIT  31
`define PTEV_LINK_IDX_W   8
`define PTEV_INT_PORT_BIT 31
`define PTEV_RST_WORD     32'h00000000
`define PTEV_HSIZE_WORD   3'h2
`endif

//--- rtl/ptev_pkg.sv
// Types shared by the pin task event unit
`include "ptev_regs.svh"
package ptev_pkg;
   typedef enum logic [1:0] {
      PTEV_MODE_OFF   = 2'h0,
      PTEV_MODE_EVENT = 2'h1,
      PTEV_MODE_TASK  = 2'h3
   } ptev_mode_e;
   typedef enum logic [1:0] {
      PTEV_POL_NONE   = 2'h0,
      PTEV_POL_RISE   = 2'h1,
      PTEV_POL_FALL   = 2'h2,
      PTEV_POL_TOGGLE = 2'h3
   } ptev_pol_e;
   // Enable on top, event fabric channel index below
   typedef logic [`PTEV_LINK_IDX_W:0] ptev_link_t;
endpackage

//--- rtl/ptev_chan.sv
// One channel: task-driven output level and input edge event
`timescale 1ns/1ps
module ptev_chan #(
   parameter int NPIN = 32
) (
   // Clock and reset
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_i,
   // Configuration
   input  wire ptev_pkg::ptev_mode_e   mode_i,
   input  wire ptev_pkg::ptev_pol_e    pol_i,
   input  wire logic [$clog2(NPIN)-1:0] psel_i,
   input  wire logic                   cfg_load_i,
   input  wire logic                   init_level_i,
   // Tasks
   input  wire logic                   out_task_i,
   input  wire logic                   set_task_i,
   input  wire logic                   drive_low_task_i,
   // Pins
   input  wire logic [NPIN-1:0]        pin_in_i,
   output logic                        level_o,
   output logic                        event_o
);
   import ptev_pkg::*;
   logic level_reg;
   logic level_next;
   logic prev_reg;
   logic load_q_reg;
   logic cur;
   logic edge_hit;

   assign cur = pin_in_i[psel_i];
   assign level_o = level_reg;

   always_comb begin
      level_next = level_reg;
      if (cfg_load_i) begin
         level_next = init_level_i;
      end else if (mode_i == PTEV_MODE_TASK) begin
         if (out_task_i) begin
            case (pol_i)
               PTEV_POL_RISE:   level_next = 1'b1;
               PTEV_POL_FALL:   level_next = 1'b0;
               PTEV_POL_TOGGLE: level_next = ~level_reg;
               default:         level_next = level_reg;
            endcase
         end else if (drive_low_task_i) begin
            level_next = 1'b0;
         end else if (set_task_i) begin
            level_next = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         level_reg  <= 1'b0;
         prev_reg   <= 1'b0;
         load_q_reg <= 1'b0;
      end else begin
         level_reg  <= level_next;
         prev_reg   <= cur;
         load_q_reg <= cfg_load_i;
      end
   end

   // Edge on the selected pin; quiet just after a reconfiguration
   always_comb begin
      case (pol_i)
         PTEV_POL_RISE:   edge_hit = cur && !prev_reg;
         PTEV_POL_FALL:   edge_hit = !cur && prev_reg;
         PTEV_POL_TOGGLE: edge_hit = cur != prev_reg;
         default:         edge_hit = 1'b0;
      endcase
   end
   assign event_o = (mode_i == PTEV_MODE_EVENT) && edge_hit && !cfg_load_i
                    && !load_q_reg;
endmodule

//--- rtl/ptev_pinmux.sv
// Pin takeover: channel direction and level or the general GPIO setting
`timescale 1ns/1ps
module ptev_pinmux #(
   parameter int NPIN = 32,
   parameter int NCH  = 8
) (
   // Channel side
   input  wire ptev_pkg::ptev_mode_e [NCH-1:0]  mode_i,
   input  wire logic [NCH-1:0][$clog2(NPIN)-1:0] psel_i,
   input  wire logic [NCH-1:0]                  level_i,
   // General GPIO side
   input  wire logic [NPIN-1:0]                 gpio_dir_i,
   input  wire logic [NPIN-1:0]                 gpio_out_i,
   // Resolved pin controls
   output logic [NPIN-1:0]                      dir_o,
   output logic [NPIN-1:0]                      out_o
);
   import ptev_pkg::*;
   localparam int PW = $clog2(NPIN);

   for (genvar p = 0; p < NPIN; p++) begin : g_pin
      logic d;
      logic o;
      always_comb begin
         d = gpio_dir_i[p];
         o = gpio_out_i[p];
         for (int c = 0; c < NCH; c++) begin
            if (psel_i[c] == PW'(p)) begin
               if (mode_i[c] == PTEV_MODE_EVENT) begin
                  d = 1'b0;
               end else if (mode_i[c] == PTEV_MODE_TASK) begin
                  d = 1'b1;
                  o = level_i[c];
               end
            end
         end
      end
      assign dir_o[p] = d;
      assign out_o[p] = o;
   end
endmodule

//--- rtl/ptev_top.sv
// Pin task event unit: AHB-Lite registers, channel tasks, events, pin takeover
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`include "ptev_regs.svh"
// ------------------------------------------------------------------
// Overview of operation
// - each channel bound to one selected pin
// - event mode forces pin to input
// - task mode drives pin, overriding GPIO
// - disabled mode leaves pin to GPIO
// - secure and non-secure instance base addresses
// - output task acts per polarity field
// - set task drives pin high
// - clear task drives pin low
// - each task has event subscription register
// - channel input event recorded per channel
// - port event from sense detect rising
// - publish registers for input and port events
// - enable-set write one enables interrupt
// - enable-clear write one disables interrupt
// - per-channel configuration register controls channel
// - output beats clear, clear beats set
// - mode codes disabled, event, task
// - polarity codes none, rise, fall, toggle
// - initial level loaded on every configuration write, in any mode
// ------------------------------------------------------------------
module ptev_top #(
   parameter logic [31:0] BASE_ADDR = `PTEV_SEC_BASE,
   parameter int          NPIN      = 32,
   parameter int          DPPI_CH   = 16
) (
   // Clock and reset
   input  wire logic               ref_clk_i,
   input  wire logic               rst_i,
   // AHB-Lite slave
   input  wire logic               hsel_i,
   input  wire logic [31:0]        haddr_i,
   input  wire logic [1:0]         htrans_i,
   input  wire logic               hwrite_i,
   input  wire logic [2:0]         hsize_i,
   input  wire logic [31:0]        hwdata_i,
   input  wire logic               hready_i,
   output logic [31:0]             hrdata_o,
   output logic                    hreadyout_o,
   output logic                    hresp_o,
   // General GPIO block and pins
   input  wire logic [NPIN-1:0]    gpio_dir_i,
   input  wire logic [NPIN-1:0]    gpio_out_i,
   input  wire logic [NPIN-1:0]    pin_in_i,
   input  wire logic               detect_i,
   output logic [NPIN-1:0]         pin_dir_o,
   output logic [NPIN-1:0]         pin_out_o,
   // Event fabric and interrupt
   input  wire logic [DPPI_CH-1:0] dppi_i,
   output logic [DPPI_CH-1:0]      pub_o,
   output logic                    irq_o
);
   import ptev_pkg::*;
   localparam int NCH = `PTEV_NCH;
   localparam int PW  = $clog2(NPIN);
   localparam int CW  = $clog2(DPPI_CH);
   localparam int LW  = `PTEV_LINK_IDX_W;
   localparam logic [11:0] TASK_BASE [3] = '{`PTEV_OFF_OUT, `PTEV_OFF_SET, `PTEV_OFF_CLR};
   localparam logic [11:0] SUB_BASE [3] =
      '{`PTEV_OFF_SUB_OUT, `PTEV_OFF_SUB_SET, `PTEV_OFF_SUB_CLR};

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   logic                   acc;
   logic                   rd_req;
   logic                   wr_pend_reg;
   logic                   rd_wait_reg;
   logic [11:0]            wr_off_reg;
   logic [11:0]            rd_off_reg;
   logic [11:0]            rd_addr;
   logic [31:0]            rd_data;
   ptev_mode_e [NCH-1:0]   mode_reg;
   ptev_pol_e [NCH-1:0]    pol_reg;
   logic [NCH-1:0][PW-1:0] psel_reg;
   logic [NCH-1:0]         init_reg;
   logic [NCH-1:0]         cfg_load;
   logic [NCH-1:0]         task_t [3];
   logic [NCH-1:0]         level;
   logic [NCH-1:0]         ch_ev;
   ptev_link_t             sub_reg [3][NCH];
   ptev_link_t             pub_reg [NCH+1];
   logic [NCH:0]           ev_reg;
   logic [NCH:0]           int_en_reg;
   logic [NCH:0]           ev_src;
   logic                   detect_q_reg;
   logic [NPIN-1:0]        mux_dir;
   logic [NPIN-1:0]        mux_out;
   logic [DPPI_CH-1:0]     pub_next;

   // ------------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------------
   function automatic logic [11:0] slot(input logic [11:0] base, input logic [11:0] port,
                                        input int k);
      return (k == NCH) ? port : base + `PTEV_STRIDE * 12'(k);
   endfunction

   function automatic logic wr_at(input logic [11:0] a);
      return wr_pend_reg && (wr_off_reg == a);
   endfunction

   function automatic logic in_rgn(input logic [11:0] a, input logic [11:0] base);
      return (a >= base) && (a < base + `PTEV_SPAN) && (a[1:0] == 2'h0);
   endfunction

   function automatic int rgn_n(input logic [11:0] a, input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      return int'(d[4:2]);
   endfunction

   function automatic logic [31:0] link_word(input ptev_link_t l);
      logic [31:0] w;
      w = `PTEV_RST_WORD;
      w[`PTEV_LINK_EN_BIT] = l[LW];
      w[LW-1:0] = l[LW-1:0];
      return w;
   endfunction

   function automatic logic link_ok(input ptev_link_t l);
      return l[LW] && (l[LW-1:0] < LW'(DPPI_CH));
   endfunction

   function automatic logic [NCH:0] en_bits(input logic [31:0] w);
      return {w[`PTEV_INT_PORT_BIT], w[NCH-1:0]};
   endfunction

   // ------------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------------
   assign acc     = hsel_i && htrans_i[1] && hready_i
                    && (haddr_i[31:12] == BASE_ADDR[31:12]);
   assign rd_req  = acc && !hwrite_i;
   assign rd_addr = rd_wait_reg ? rd_off_reg : haddr_i[11:0];

   // Read right behind a write waits one cycle to see the written value
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_pend_reg <= 1'b0;
         wr_off_reg  <= 12'h000;
         rd_wait_reg <= 1'b0;
         rd_off_reg  <= 12'h000;
         hrdata_o    <= `PTEV_RST_WORD;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         wr_pend_reg <= acc && hwrite_i && (hsize_i == `PTEV_HSIZE_WORD);
         if (acc && hwrite_i) begin
            wr_off_reg <= haddr_i[11:0];
         end
         rd_wait_reg <= rd_req && wr_pend_reg;
         if (rd_req) begin
            rd_off_reg <= haddr_i[11:0];
         end
         hreadyout_o <= !(rd_req && wr_pend_reg);
         hresp_o     <= 1'b0;
         if ((rd_req && !wr_pend_reg) || rd_wait_reg) begin
            hrdata_o <= rd_data;
         end else begin
            hrdata_o <= `PTEV_RST_WORD;
         end
      end
   end

   always_comb begin
      rd_data = `PTEV_RST_WORD;
      for (int t = 0; t < 3; t++) begin
         if (in_rgn(rd_addr, SUB_BASE[t])) begin
            rd_data = link_word(sub_reg[t][rgn_n(rd_addr, SUB_BASE[t])]);
         end
      end
      for (int k = 0; k <= NCH; k++) begin
         if (rd_addr == slot(`PTEV_OFF_EV_IN, `PTEV_OFF_EV_PORT, k)) begin
            rd_data[0] = ev_reg[k];
         end
         if (rd_addr == slot(`PTEV_OFF_PUB_IN, `PTEV_OFF_PUB_PORT, k)) begin
            rd_data = link_word(pub_reg[k]);
         end
      end
      if (rd_addr == `PTEV_OFF_INTERRUPT_ENABLE_SET || rd_addr == `PTEV_OFF_INTERRUPT_ENABLE_CLEAR) begin
         rd_data[NCH-1:0] = int_en_reg[NCH-1:0];
         rd_data[`PTEV_INT_PORT_BIT] = int_en_reg[NCH];
      end
      if (in_rgn(rd_addr, `PTEV_OFF_CFG)) begin
         rd_data[`PTEV_CFG_MODE_MSB:`PTEV_CFG_MODE_LSB] =
            mode_reg[rgn_n(rd_addr, `PTEV_OFF_CFG)];
         rd_data[`PTEV_CFG_PSEL_LSB +: PW] = psel_reg[rgn_n(rd_addr, `PTEV_OFF_CFG)];
         rd_data[`PTEV_CFG_POL_MSB:`PTEV_CFG_POL_LSB] = pol_reg[rgn_n(rd_addr, `PTEV_OFF_CFG)];
         rd_data[`PTEV_CFG_INIT_BIT] = init_reg[rgn_n(rd_addr, `PTEV_OFF_CFG)];
      end
   end

   // ------------------------------------------------------------------
   // Tasks from software writes and subscribed fabric channels
   // ------------------------------------------------------------------
   always_comb begin
      for (int t = 0; t < 3; t++) begin
         for (int n = 0; n < NCH; n++) begin
            task_t[t][n] = (wr_at(slot(TASK_BASE[t], 12'h000, n)) && hwdata_i[0])
                           || (link_ok(sub_reg[t][n])
                               && dppi_i[sub_reg[t][n][CW-1:0]]);
         end
      end
      for (int n = 0; n < NCH; n++) begin
         cfg_load[n] = wr_at(slot(`PTEV_OFF_CFG, 12'h000, n));
      end
   end

   // ------------------------------------------------------------------
   // Channel configuration
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_reg <= '{default: PTEV_MODE_OFF};
         pol_reg  <= '{default: PTEV_POL_NONE};
         psel_reg <= '0;
         init_reg <= '0;
      end else begin
         for (int n = 0; n < NCH; n++) begin
            if (cfg_load[n]) begin
               mode_reg[n] <= ptev_mode_e'(hwdata_i[`PTEV_CFG_MODE_MSB:`PTEV_CFG_MODE_LSB]);
               pol_reg[n]  <= ptev_pol_e'(hwdata_i[`PTEV_CFG_POL_MSB:`PTEV_CFG_POL_LSB]);
               init_reg[n] <= hwdata_i[`PTEV_CFG_INIT_BIT];
               if (mode_reg[n] != PTEV_MODE_EVENT && mode_reg[n] != PTEV_MODE_TASK) begin
                  psel_reg[n] <= hwdata_i[`PTEV_CFG_PSEL_LSB +: PW];
               end
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Subscription and publication registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sub_reg <= '{default: '{default: '0}};
         pub_reg <= '{default: '0};
      end else begin
         for (int t = 0; t < 3; t++) begin
            for (int n = 0; n < NCH; n++) begin
               if (wr_at(slot(SUB_BASE[t], 12'h000, n))) begin
                  sub_reg[t][n] <= {hwdata_i[`PTEV_LINK_EN_BIT], hwdata_i[LW-1:0]};
               end
            end
         end
         for (int k = 0; k <= NCH; k++) begin
            if (wr_at(slot(`PTEV_OFF_PUB_IN, `PTEV_OFF_PUB_PORT, k))) begin
               pub_reg[k] <= {hwdata_i[`PTEV_LINK_EN_BIT], hwdata_i[LW-1:0]};
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Events and interrupt enables
   // ------------------------------------------------------------------
   assign ev_src = {detect_i && !detect_q_reg, ch_ev};

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ev_reg       <= '0;
         detect_q_reg <= 1'b0;
      end else begin
         detect_q_reg <= detect_i;
         for (int k = 0; k <= NCH; k++) begin
            if (ev_src[k]) begin
               ev_reg[k] <= 1'b1;
            end else if (wr_at(slot(`PTEV_OFF_EV_IN, `PTEV_OFF_EV_PORT, k)) && !hwdata_i[0]) begin
               ev_reg[k] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         int_en_reg <= '0;
      end else begin
         int_en_reg <= (int_en_reg | (wr_at(`PTEV_OFF_INTERRUPT_ENABLE_SET) ? en_bits(hwdata_i) : '0))
                       & ~(wr_at(`PTEV_OFF_INTERRUPT_ENABLE_CLEAR) ? en_bits(hwdata_i) : '0);
      end
   end

   always_comb begin
      pub_next = '0;
      for (int k = 0; k <= NCH; k++) begin
         if (ev_src[k] && link_ok(pub_reg[k])) begin
            pub_next[pub_reg[k][CW-1:0]] = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Channels and pin takeover
   // ------------------------------------------------------------------
   for (genvar n = 0; n < NCH; n++) begin : g_ch
      ptev_chan #(.NPIN(NPIN)) u_chan (
         .ref_clk_i        (ref_clk_i),
         .rst_i            (rst_i),
         .mode_i           (mode_reg[n]),
         .pol_i            (pol_reg[n]),
         .psel_i           (psel_reg[n]),
         .cfg_load_i       (cfg_load[n]),
         .init_level_i     (hwdata_i[`PTEV_CFG_INIT_BIT]),
         .out_task_i       (task_t[0][n]),
         .set_task_i       (task_t[1][n]),
         .drive_low_task_i (task_t[2][n]),
         .pin_in_i         (pin_in_i),
         .level_o          (level[n]),
         .event_o          (ch_ev[n])
      );
   end

   ptev_pinmux #(.NPIN(NPIN), .NCH(NCH)) u_pinmux (
      .mode_i     (mode_reg),
      .psel_i     (psel_reg),
      .level_i    (level),
      .gpio_dir_i (gpio_dir_i),
      .gpio_out_i (gpio_out_i),
      .dir_o      (mux_dir),
      .out_o      (mux_out)
   );

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_dir_o <= '0;
         pin_out_o <= '0;
         pub_o     <= '0;
         irq_o     <= 1'b0;
      end else begin
         pin_dir_o <= mux_dir;
         pin_out_o <= mux_out;
         pub_o     <= pub_next;
         irq_o     <= |(ev_reg & int_en_reg);
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_event_dir;
      mode_reg[0] == PTEV_MODE_EVENT |=> !pin_dir_o[$past(psel_reg[0])];
   endproperty
   a_event_dir: assert property (p_event_dir) else $error("event pin not input");

   property p_task_pin;
      mode_reg[0] == PTEV_MODE_TASK |=> pin_dir_o[$past(psel_reg[0])]
         && (pin_out_o[$past(psel_reg[0])] == $past(level[0]));
   endproperty
   a_task_pin: assert property (p_task_pin) else $error("task pin not driven");

   property p_gpio_pass;
      mode_reg == '0 |=> (pin_dir_o == $past(gpio_dir_i)) && (pin_out_o == $past(gpio_out_i));
   endproperty
   a_gpio_pass: assert property (p_gpio_pass) else $error("gpio not passed");

   property p_set_high;
      mode_reg[0] == PTEV_MODE_TASK && task_t[1][0] && !task_t[2][0] && !task_t[0][0]
         && !cfg_load[0] |=> level[0];
   endproperty
   a_set_high: assert property (p_set_high) else $error("set task failed");

   property p_clr_low;
      mode_reg[0] == PTEV_MODE_TASK && task_t[2][0] && !task_t[0][0] && !cfg_load[0]
         |=> !level[0];
   endproperty
   a_clr_low: assert property (p_clr_low) else $error("clear task failed");

   property p_out_prio;
      mode_reg[0] == PTEV_MODE_TASK && pol_reg[0] == PTEV_POL_NONE && task_t[0][0]
         && !cfg_load[0] |=> $stable(level[0]);
   endproperty
   a_out_prio: assert property (p_out_prio) else $error("output task lost priority");

   property p_toggle;
      mode_reg[0] == PTEV_MODE_TASK && pol_reg[0] == PTEV_POL_TOGGLE && task_t[0][0]
         && !cfg_load[0] |=> level[0] != $past(level[0]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle failed");

   property p_init;
      cfg_load[0] |=> level[0] == $past(hwdata_i[`PTEV_CFG_INIT_BIT]);
   endproperty
   a_init: assert property (p_init) else $error("initial level wrong");

   property p_irq;
      (|(ev_reg & int_en_reg)) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

   property p_en_set;
      wr_at(`PTEV_OFF_INTERRUPT_ENABLE_SET) |=> (int_en_reg & $past(en_bits(hwdata_i)))
         == $past(en_bits(hwdata_i));
   endproperty
   a_en_set: assert property (p_en_set) else $error("enable set failed");

   property p_en_keep;
      wr_at(`PTEV_OFF_INTERRUPT_ENABLE_SET) |=> ($past(int_en_reg) & ~int_en_reg) == '0;
   endproperty
   a_en_keep: assert property (p_en_keep) else $error("enable lost on set");

   c_toggle: cover property (task_t[0][0] && pol_reg[0] == PTEV_POL_TOGGLE);
   c_ev_irq: cover property (ev_reg[0] && int_en_reg[0] ##1 irq_o);
   c_port:   cover property (ev_src[NCH]);
   c_rdwait: cover property (rd_wait_reg);
endmodule

//--- tb/tb_ptev_top.sv
// Self-checking bench for the pin task event unit
`timescale 1ns/1ps
`include "ptev_regs.svh"
module tb_ptev_top;
   localparam logic [11:0] T_OUT = 12'h000, T_SET = 12'h030, T_LOW = 12'h060, EV_IN = 12'h100;
   localparam logic [11:0] EV_PRT = 12'h17c, IE_SET = 12'h304, IE_CLR = 12'h308, CFG = 12'h510;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0]  htrans = '0;
   logic        hwrite = 1'b0, hready, hresp, irq, detect = 1'b0, rd_ph = 1'b0;
   logic [31:0] gdir = '0, gout = '0, pin_in = '0, pdir, pout;
   logic [15:0] pub;
   logic [15:0] dppi = '0;
   int          n_pub = 0;
   logic [31:0] expq[$];
   logic [1:0]  pol;
   int          n_mismatch = 0, check_count = 0, cyc = 0, p, q;
   always #10 clk = ~clk;
   ptev_top dut_u (.ref_clk_i(clk), .rst_i(rst), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(`PTEV_HSIZE_WORD), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .gpio_dir_i(gdir), .gpio_out_i(gout), .pin_in_i(pin_in), .detect_i(detect),
      .pin_dir_o(pdir), .pin_out_o(pout), .dppi_i(dppi), .pub_o(pub), .irq_o(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Single word transfer, held until hready is sampled high
   task automatic xfer(input logic [11:0] off, input logic wr, input logic [31:0] d);
      @(posedge clk);
      haddr <= `PTEV_SEC_BASE | {20'h0, off};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
   endtask
   task automatic wr(input logic [11:0] off, input logic [31:0] d);
      xfer(off, 1'b1, d);
   endtask
   task automatic rd(input logic [11:0] off, input logic [31:0] exp);
      expq.push_back(exp);
      xfer(off, 1'b0, 32'h0);
   endtask
   task automatic pin(input int i, input logic d, input logic o);
      repeat (3) @(posedge clk);
      #1 chk({30'h0, pdir[i], pout[i]}, {30'h0, d, o});
   endtask
   // Read data watcher and hang guard
   always @(posedge clk) begin
      if (rd_ph && hready === 1'b1) chk(hrdata, expq.pop_front());
      if (hready === 1'b1) rd_ph <= htrans[1] & ~hwrite;
      if (pub[2] === 1'b1) n_pub++;
      cyc++;
      if (cyc > 5000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      void'($urandom(76761));
      p = $urandom % 32;
      q = (p + 1 + $urandom % 31) % 32;
      gdir <= $urandom;
      gout <= $urandom;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(IE_SET, 32'h0);
      wr(IE_SET, 32'h80000081);
      wr(IE_CLR, 32'h00000001);
      wr(IE_SET, 32'h0);
      wr(IE_CLR, 32'h0);
      rd(IE_SET, 32'h80000080);
      rd(IE_CLR, 32'h80000080);
      rd(12'h400, 32'h0);
      $display("test interrupt enables done");
      wr(CFG, 32'h00130003 | (p << 8));
      pin(p, 1'b1, 1'b1);
      wr(T_LOW, 32'h1);
      pin(p, 1'b1, 1'b0);
      wr(T_SET, 32'h1);
      pin(p, 1'b1, 1'b1);
      wr(T_OUT, 32'h1);
      pin(p, 1'b1, 1'b0);
      for (int k = 0; k < 3; k++) begin
         pol = k[1:0];
         wr(CFG, {11'h0, pol[1], 2'h0, pol, 3'h0, p[4:0], 8'h03});
         wr(T_OUT, 32'h1);
         pin(p, 1'b1, pol == 2'h1);
      end
      wr(CFG, p << 8);
      pin(p, gdir[p], gout[p]);
      $display("test task mode done");
      wr(CFG + 12'h01c, 32'h00010001 | (q << 8));
      repeat (3) @(posedge clk);
      #1 chk({31'h0, pdir[q]}, 32'h0);
      @(posedge clk);
      pin_in[q] <= 1'b1;
      repeat (3) @(posedge clk);
      rd(EV_IN + 12'h01c, 32'h1);
      #1 chk({31'h0, irq}, 32'h1);
      wr(EV_IN + 12'h01c, 32'h0);
      repeat (3) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0);
      $display("test input event done");
      wr(12'h1fc, 32'h80000002);
      detect <= 1'b1;
      repeat (3) @(posedge clk);
      rd(EV_PRT, 32'h1);
      #1 chk({31'h0, irq}, 32'h1);
      chk(n_pub, 32'h1);
      $display("test port event done");
      wr(CFG, 32'h00000003 | (p << 8));
      wr(12'h0b0, 32'h80000003);
      pin(p, 1'b1, 1'b0);
      @(posedge clk);
      dppi <= 16'h0008;
      @(posedge clk);
      dppi <= 16'h0000;
      pin(p, 1'b1, 1'b1);
      $display("test subscription done");
      summarize();
   end
endmodule
